/* rtl/pmio_pkg.sv */
package pmio_pkg;

    // ------------------------------------------------------------
    // instruction cycle phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_A1,
        PH_A2,
        PH_A3,
        PH_M1,
        PH_M2,
        PH_X1,
        PH_X2,
        PH_X3
    } phase_t;

    // ------------------------------------------------------------
    // opcodes and widths
    // ------------------------------------------------------------
    localparam logic [3:0] OPR_IO_GROUP      = 4'hE;
    localparam logic [3:0] OPA_PROG_WRITE    = 4'h3;
    localparam logic [3:0] OPA_WRITE_PORT    = 4'h2;
    localparam logic [3:0] OPA_READ_PORT     = 4'hA;
    localparam logic [3:0] OPR_SEND_REG_CTRL = 4'h2;
    localparam logic [3:0] PAGE_WRITE_CHAN   = 4'hF;
    localparam logic [7:0] ADDR_RESET        = 8'h00;
    localparam logic [3:0] PAGE_RESET        = 4'h0;
    localparam logic       HALF_RESET        = 1'b1;
    localparam int         FIFO_DEPTH        = 32;
    localparam int         FIFO_WIDTH        = 4;

endpackage

/* rtl/nibble_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module nibble_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = mem_q[rd_q];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule // nibble_fifo

`default_nettype wire

/* rtl/program_memory_io_interface.sv */
`timescale 1ns/1ps
`default_nettype none

module program_memory_io_interface (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       sync_in,
    input  wire logic       program_command_line_in,
    input  wire logic [3:0] cpu_data_in,
    output logic      [3:0] cpu_data_out,
    output logic            cpu_data_oe_out,
    output logic      [7:0] address_out,
    output logic      [3:0] page_select_out,
    input  wire logic [7:0] memory_data_in,
    output logic            program_write_out,
    output logic            half_select_out,
    input  wire logic [3:0] port_bus_in,
    output logic      [3:0] port_bus_out,
    output logic            port_bus_oe_out,
    output logic            read_strobe_out,
    output logic            write_strobe_out,
    output logic            fifo_valid_out,
    input  wire logic       fifo_ready_in,
    output logic      [3:0] fifo_data_out,
    output logic            fifo_ready_out
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic       sync_s1_q;
    logic       sync_s2_q;
    logic       cmd_s1_q;
    logic       cmd_s2_q;
    logic [3:0] data_s1_q;
    logic [3:0] data_s2_q;
    logic [7:0] mem_s1_q;
    logic [7:0] mem_s2_q;
    logic [3:0] port_s1_q;
    logic [3:0] port_s2_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync_s1_q <= 1'b0;
            sync_s2_q <= 1'b0;
            cmd_s1_q  <= 1'b0;
            cmd_s2_q  <= 1'b0;
            data_s1_q <= 4'h0;
            data_s2_q <= 4'h0;
            mem_s1_q  <= 8'h00;
            mem_s2_q  <= 8'h00;
            port_s1_q <= 4'h0;
            port_s2_q <= 4'h0;
        end else begin
            sync_s1_q <= sync_in;
            sync_s2_q <= sync_s1_q;
            cmd_s1_q  <= program_command_line_in;
            cmd_s2_q  <= cmd_s1_q;
            data_s1_q <= cpu_data_in;
            data_s2_q <= data_s1_q;
            mem_s1_q  <= memory_data_in;
            mem_s2_q  <= mem_s1_q;
            port_s1_q <= port_bus_in;
            port_s2_q <= port_s1_q;
        end
    end

    // ------------------------------------------------------------
    // phase tracking
    // ------------------------------------------------------------
    pmio_pkg::phase_t phase_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_q <= pmio_pkg::PH_A1;
        end else if (sync_s2_q) begin
            phase_q <= pmio_pkg::PH_A1;
        end else begin
            phase_q <= pmio_pkg::phase_t'(phase_q + 3'd1);
        end
    end

    function automatic logic is_phase(input pmio_pkg::phase_t p,
                                      input pmio_pkg::phase_t want);
        is_phase = (p == want);
    endfunction

    // ------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------
    // eight-bit word address, four-bit page
    logic [7:0] prog_addr_q;
    logic [3:0] page_q;
    logic [7:0] ctrl_addr_q;
    logic       out_valid_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prog_addr_q <= pmio_pkg::ADDR_RESET;
        end else if (is_phase(phase_q, pmio_pkg::PH_A1)) begin
            prog_addr_q[3:0] <= data_s2_q;
        end else if (is_phase(phase_q, pmio_pkg::PH_A2)) begin
            prog_addr_q[7:4] <= data_s2_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            page_q <= pmio_pkg::PAGE_RESET;
        end else if (is_phase(phase_q, pmio_pkg::PH_A3) && cmd_s2_q) begin
            page_q <= data_s2_q;
        end
    end

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    logic [7:0] instr_q;
    logic       fetch_q;
    logic       src_pending_q;
    logic       src_hi_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            fetch_q <= 1'b0;
        end else if (is_phase(phase_q, pmio_pkg::PH_A3)) begin
            fetch_q <= cmd_s2_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            instr_q <= 8'h00;
        end else if (is_phase(phase_q, pmio_pkg::PH_M1) && fetch_q) begin
            instr_q <= mem_s2_q;
        end
    end

    logic op_io;
    logic op_prog_write;
    logic op_read_port;
    logic op_write_port;
    logic op_src;

    assign op_io         = fetch_q && (instr_q[7:4] == pmio_pkg::OPR_IO_GROUP);
    assign op_prog_write = op_io && (instr_q[3:0] == pmio_pkg::OPA_PROG_WRITE);
    assign op_read_port  = op_io && (instr_q[3:0] == pmio_pkg::OPA_READ_PORT);
    assign op_write_port = op_io && (instr_q[3:0] == pmio_pkg::OPA_WRITE_PORT);
    assign op_src        = fetch_q && (instr_q[7:4] == pmio_pkg::OPR_SEND_REG_CTRL)
                           && instr_q[0];

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_addr_q <= pmio_pkg::ADDR_RESET;
        end else if (op_src && cmd_s2_q && is_phase(phase_q, pmio_pkg::PH_X2)) begin
            ctrl_addr_q[7:4] <= data_s2_q;
        end else if (op_src && is_phase(phase_q, pmio_pkg::PH_X3)) begin
            ctrl_addr_q[3:0] <= data_s2_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            half_select_out <= pmio_pkg::HALF_RESET;
        end else if (op_prog_write && is_phase(phase_q, pmio_pkg::PH_X3)) begin
            half_select_out <= ~half_select_out;
        end
    end

    // ------------------------------------------------------------
    // address and page outputs
    // ------------------------------------------------------------
    // positive logic, no inversion on any line
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            address_out     <= pmio_pkg::ADDR_RESET;
            page_select_out <= pmio_pkg::PAGE_RESET;
            out_valid_q     <= 1'b0;
        end else if (is_phase(phase_q, pmio_pkg::PH_X1)) begin
            address_out <= ctrl_addr_q;
            page_select_out <= op_prog_write ? pmio_pkg::PAGE_WRITE_CHAN
                                             : ctrl_addr_q[7:4];
        end else if (is_phase(phase_q, pmio_pkg::PH_M1) && out_valid_q) begin
            address_out     <= prog_addr_q;
            page_select_out <= page_q;
        end else if (is_phase(phase_q, pmio_pkg::PH_A3) && cmd_s2_q) begin
            address_out     <= prog_addr_q;
            page_select_out <= data_s2_q;
            out_valid_q     <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            program_write_out <= 1'b0;
        end else begin
            program_write_out <= op_prog_write
                && (is_phase(phase_q, pmio_pkg::PH_X1)
                    || is_phase(phase_q, pmio_pkg::PH_X2));
        end
    end

    // ------------------------------------------------------------
    // transfer part
    // ------------------------------------------------------------
    // instruction nibbles and read port nibble to cpu
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cpu_data_out    <= 4'h0;
            cpu_data_oe_out <= 1'b0;
        end else if (is_phase(phase_q, pmio_pkg::PH_M1) && fetch_q) begin
            cpu_data_out    <= mem_s2_q[7:4];
            cpu_data_oe_out <= 1'b1;
        end else if (is_phase(phase_q, pmio_pkg::PH_M2) && fetch_q) begin
            cpu_data_out    <= instr_q[3:0];
            cpu_data_oe_out <= 1'b1;
        end else if (is_phase(phase_q, pmio_pkg::PH_X2) && op_read_port) begin
            cpu_data_out    <= port_s2_q;
            cpu_data_oe_out <= 1'b1;
        end else begin
            cpu_data_oe_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            read_strobe_out <= 1'b0;
        end else begin
            read_strobe_out <= op_read_port && is_phase(phase_q, pmio_pkg::PH_X1);
        end
    end

    // ------------------------------------------------------------
    // outbound nibble buffer
    // ------------------------------------------------------------
    logic       push_valid;
    logic [3:0] fifo_out_data;
    logic       fifo_out_valid;
    logic       fifo_in_ready;

    assign push_valid = (op_write_port || op_prog_write)
                        && is_phase(phase_q, pmio_pkg::PH_X2);

    nibble_fifo #(
        .WIDTH (pmio_pkg::FIFO_WIDTH),
        .DEPTH (pmio_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (data_s2_q),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_ready_in),
        .out_data_out  (fifo_out_data)
    );

    assign fifo_valid_out = fifo_out_valid;
    assign fifo_data_out  = fifo_out_data;
    assign fifo_ready_out = fifo_in_ready;

    // port bus shows the nibble one clock later, only while the buffer has room; the buffer copy is for a slow consumer
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            port_bus_out     <= 4'h0;
            port_bus_oe_out  <= 1'b0;
            write_strobe_out <= 1'b0;
        end else begin
            if (push_valid) begin
                port_bus_out <= data_s2_q;
            end
            port_bus_oe_out  <= push_valid && fifo_in_ready;
            write_strobe_out <= push_valid && op_write_port && fifo_in_ready;
        end
    end

endmodule // program_memory_io_interface

`default_nettype wire

/* bench/cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------
// cpu side of the nibble bus
// --------------------
module cpu_model (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       go_in,
    input  wire logic [7:0] op_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [3:0] page_in,
    input  wire logic [3:0] acc_in,
    input  wire logic [7:0] src_in,
    output logic            taken_out,
    output logic            sync_out,
    output logic            cmd_out,
    output logic            drive_out,
    output logic      [3:0] data_out,
    output logic      [7:0] mem_out
);
    logic [2:0] ph_q = 3'h0;
    logic       live_q = 1'b0;
    logic [7:0] op_q = 8'h00, ad_q = 8'h00, sr_q = 8'h00;
    logic [3:0] pg_q = 4'h0, ac_q = 4'h0;
    logic       io_c, out_c, src_c;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ph_q   <= 3'h0;
            live_q <= 1'b0;
        end else begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h7) begin
                live_q <= go_in;
                {op_q, ad_q, pg_q, ac_q, sr_q} <= {op_in, addr_in, page_in, acc_in, src_in};
            end
        end
    end

    assign taken_out = ph_q == 3'h7;
    assign sync_out  = ph_q == 3'h7;
    assign io_c      = op_q[7:4] == 4'hE;
    assign out_c     = io_c && op_q[3:0] != 4'hA;
    assign src_c     = op_q[7:4] == 4'h2 && op_q[0];
    assign cmd_out = live_q && (ph_q == 3'h2 || (io_c && ph_q == 3'h4) || (src_c && ph_q == 3'h6));
    assign drive_out = ph_q < 3'h3 || (live_q && (out_c || src_c) && ph_q == 3'h6)
                       || (live_q && src_c && ph_q == 3'h7);
    // memory only answers in the two memory phases; elsewhere it keeps changing
    assign mem_out = (ph_q == 3'h3 || ph_q == 3'h4) ? op_q : {ph_q, ph_q, ph_q[1:0]} ^ 8'h5A;

    always_comb begin
        case (ph_q)
            3'h0: data_out = ad_q[3:0];
            3'h1: data_out = ad_q[7:4];
            3'h2: data_out = pg_q;
            3'h6: data_out = src_c ? sr_q[7:4] : ac_q;
            3'h7: data_out = sr_q[3:0];
            default: data_out = {ph_q, ph_q[0]} ^ 4'hA;
        endcase
    end
endmodule // cpu_model
`default_nettype wire

/* bench/pmio_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------
// port checks of the bridge
// --------------------
module pmio_monitor (
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic [7:0] address_out,
    input wire logic [3:0] page_select_out,
    input wire logic       program_write_out,
    input wire logic       half_select_out,
    input wire logic       port_bus_oe_out,
    input wire logic       read_strobe_out,
    input wire logic       write_strobe_out,
    input wire logic       fifo_valid_out,
    input wire logic       fifo_ready_in,
    input wire logic [3:0] fifo_data_out,
    input wire logic       fifo_ready_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    reset_vals_a: assert property ($fell(reset_in) |-> half_select_out
        && address_out == 8'h00 && page_select_out == 4'h0 && !program_write_out)
        else $error("outputs not at reset values");
    pw_page_a: assert property (program_write_out |-> page_select_out == 4'hF)
        else $error("page not forced in program write");
    pw_len_a: assert property ($rose(program_write_out) |=> program_write_out ##1 !program_write_out)
        else $error("program write length wrong");
    pw_hold_a: assert property (program_write_out && $past(program_write_out) |->
        $stable(address_out) && $stable(half_select_out))
        else $error("address or half moved in program write");
    half_step_a: assert property ($changed(half_select_out) |->
        $past(program_write_out) || $past(program_write_out, 2))
        else $error("half select moved without program write");
    rd_quiet_a: assert property (read_strobe_out |-> !port_bus_oe_out && !write_strobe_out)
        else $error("port bus driven during read");
    rd_space_a: assert property (read_strobe_out |=> !read_strobe_out [*7])
        else $error("read strobes too close");
    wr_space_a: assert property (write_strobe_out |=> !write_strobe_out [*7])
        else $error("write strobes too close");
    full_block_a: assert property ((!fifo_ready_out) [*5] |-> !write_strobe_out)
        else $error("write strobe while buffer full");
    fifo_hold_a: assert property (fifo_valid_out && !fifo_ready_in |=>
        fifo_valid_out && $stable(fifo_data_out))
        else $error("buffer output dropped while stalled");

    cover property ($rose(program_write_out));
    cover property (read_strobe_out);
    cover property (!fifo_ready_out && write_strobe_out);
endmodule // pmio_monitor

bind program_memory_io_interface pmio_monitor mon (
    .clk_in(clk_in), .reset_in(reset_in), .address_out(address_out),
    .page_select_out(page_select_out), .program_write_out(program_write_out),
    .half_select_out(half_select_out), .port_bus_oe_out(port_bus_oe_out),
    .read_strobe_out(read_strobe_out), .write_strobe_out(write_strobe_out),
    .fifo_valid_out(fifo_valid_out), .fifo_ready_in(fifo_ready_in),
    .fifo_data_out(fifo_data_out), .fifo_ready_out(fifo_ready_out)
);
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_in = 1'b0, reset_in = 1'b1, go = 1'b0, fifo_ready_in = 1'b1;
    logic [7:0]  op = 8'h00, addr = 8'h00, src = 8'h00, mem, address_out, ea, pw_addr;
    logic [3:0]  page = 4'h0, acc = 4'h0, port_bus_in = 4'h0, m_dat, cpu_bus, ep, pw_pg;
    logic [3:0]  cpu_data_out, page_select_out, port_bus_out, fifo_data_out;
    logic        sync, cmd, m_drv, taken, cpu_data_oe_out, program_write_out, half_select_out;
    logic        port_bus_oe_out, read_strobe_out, write_strobe_out, fifo_valid_out;
    logic        fifo_ready_out, pw_half, pg_any = 1'b0;
    logic [31:0] rnd = 32'h864B;
    logic [3:0]  cq[$], pq[$], fq[$], efq[$];
    int          n_fail = 0, checks_done = 0, rd_n, wr_n, pw_n, hit_n, exp_half = 1;

    always #5 clk_in = ~clk_in;
    // released cpu bus shows a changing pattern, never the last value
    assign cpu_bus = m_drv ? m_dat : (cpu_data_oe_out ? cpu_data_out : ~m_dat);

    program_memory_io_interface dut (
        .clk_in(clk_in), .reset_in(reset_in), .sync_in(sync),
        .program_command_line_in(cmd), .cpu_data_in(cpu_bus),
        .cpu_data_out(cpu_data_out), .cpu_data_oe_out(cpu_data_oe_out),
        .address_out(address_out), .page_select_out(page_select_out),
        .memory_data_in(mem), .program_write_out(program_write_out),
        .half_select_out(half_select_out), .port_bus_in(port_bus_in),
        .port_bus_out(port_bus_out), .port_bus_oe_out(port_bus_oe_out),
        .read_strobe_out(read_strobe_out), .write_strobe_out(write_strobe_out),
        .fifo_valid_out(fifo_valid_out), .fifo_ready_in(fifo_ready_in),
        .fifo_data_out(fifo_data_out), .fifo_ready_out(fifo_ready_out));
    cpu_model cpu (
        .clk_in(clk_in), .reset_in(reset_in), .go_in(go), .op_in(op), .addr_in(addr),
        .page_in(page), .acc_in(acc), .src_in(src), .taken_out(taken), .sync_out(sync),
        .cmd_out(cmd), .drive_out(m_drv), .data_out(m_dat), .mem_out(mem));

    always @(posedge clk_in) begin
        if (cpu_data_oe_out) cq.push_back(cpu_data_out);
        if (port_bus_oe_out) pq.push_back(port_bus_out);
        if (fifo_valid_out && fifo_ready_in) fq.push_back(fifo_data_out);
        if (read_strobe_out) rd_n++;
        if (write_strobe_out) wr_n++;
        if (program_write_out && pw_n == 0) {pw_addr, pw_pg, pw_half} = {address_out, page_select_out, half_select_out};
        if (program_write_out) pw_n++;
        if (address_out === ea && (pg_any || page_select_out === ep)) hit_n++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rand_in();
        rnd = lfsr(rnd);
        {port_bus_in, acc, page, addr} <= rnd[19:0];
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // one real cycle, then five clocks into an idle one so late outputs settle
    task automatic run(input logic [7:0] o, input logic f);
        cq.delete();
        pq.delete();
        {rd_n, wr_n, pw_n, hit_n} = '0;
        op <= o;
        go <= f;
        repeat (2) begin
            do @(posedge clk_in); while (taken !== 1'b1);
            go <= 1'b0;
        end
        repeat (5) @(posedge clk_in);
    endtask
    task automatic fifo_cmp();
        chk("fifo n", efq.size(), fq.size());
        foreach (efq[i]) chk("fifo", efq[i], fq[i]);
        efq.delete();
        fq.delete();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        chk("reset", {8'h00, 4'h0, 1'b1}, {address_out, page_select_out, half_select_out});
        reset_in <= 1'b0;
        run(8'h00, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rand_in();
            {ep, ea} = rnd[11:0];
            run({4'hD, rnd[23:20]}, 1'b1);
            chk("nib n", 2, cq.size());
            chk("op", {4'hD, rnd[23:20]}, {cq[0], cq[1]});
            chk("addr page", 1'b1, hit_n > 0);
        end
        rand_in();
        page <= ~ep | 4'h1;
        {ep, ea} = {~ep | 4'h1, rnd[7:0]};
        run(8'hD5, 1'b0);
        chk("no fetch", 0, cq.size() + hit_n);
        rand_in();
        src <= rnd[27:20];
        ea = rnd[27:20];
        pg_any = 1'b1;
        run({4'h2, rnd[31:29], 1'b1}, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rand_in();
            run(8'hE3, 1'b1);
            chk("src x1", 1'b1, hit_n > 0);
            chk("pw", 1'b1, pw_n > 0);
            chk("pw page", 4'hF, pw_pg);
            chk("pw addr", ea, pw_addr);
            chk("pw half", exp_half, pw_half);
            chk("pw bus", {1'b1, acc}, {pq.size() == 1, pq[0]});
            efq.push_back(acc);
            exp_half ^= 1;
            chk("half", exp_half, half_select_out);
        end
        rand_in();
        run(8'hEA, 1'b1);
        chk("rd strobe", 1, rd_n);
        chk("rd nibs", {1'b1, 4'hE, 4'hA, port_bus_in}, {cq.size() == 3, cq[0], cq[1], cq[2]});
        rand_in();
        run(8'hE2, 1'b1);
        chk("wr", {1'b1, 1'b1, acc}, {wr_n == 1, pq.size() == 1, pq[0]});
        efq.push_back(acc);
        fifo_cmp();
        fifo_ready_in <= 1'b0;
        for (int i = 0; i < 34; i++) begin
            acc <= i[3:0];
            run(8'hE2, 1'b1);
            chk("wr full", i < 32, wr_n);
            if (i < 32) efq.push_back(i[3:0]);
        end
        chk("full", 1'b0, fifo_ready_out);
        repeat (200) begin
            @(posedge clk_in);
            rnd = lfsr(rnd);
            fifo_ready_in <= rnd[0];
        end
        fifo_cmp();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
